/* File: verilog/shsc_pkg.sv */
// standby controller package: register map, field positions, reset values,
// wait counts and clock restart timing; also the small wait timer.
// assumes a single 25 MHz clock and a synchronous active-low reset.
`timescale 1ns/100ps

// ************************************************************
// package
// ************************************************************
package shsc_pkg;
   // cpu clock source as reported by the clock generator
   typedef enum logic [1:0] {
      CLK_HS_INTERNAL_OSC,
      CLK_MAIN_CRYSTAL,
      CLK_EXT_MAIN,
      CLK_SUBSYSTEM
   } shsc_clk_src_t;

   localparam int CNT_W = 11;

   // register byte offsets
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] OPT_OFS = 12'h004;
   localparam logic [11:0] STAT_OFS = 12'h008;

   // control register fields
   localparam int CTRL_LP_BIT = 0;
   localparam int CTRL_ITC_BIT = 1;
   localparam int CTRL_CO_SUB_BIT = 2;
   localparam int CTRL_CO_EN_BIT = 3;
   localparam int CTRL_SUBXT_BIT = 4;
   localparam int CTRL_W = 5;
   // option bits, kept at their option-byte positions
   localparam int OPT_WDSTBY_BIT = 0;
   localparam int OPT_WDEN_BIT = 4;
   localparam int OPT_W = 5;
   // status register fields
   localparam int STAT_SKIP_BIT = 4;
   localparam int STAT_REFUSE_BIT = 5;
   localparam int STAT_VEC_BIT = 6;
   localparam int STAT_STBY_BIT = 8;

   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
   localparam logic [OPT_W-1:0] OPT_RST = 5'h00;

   // resume waits in cpu clocks, lower end of each documented range
   localparam logic [CNT_W-1:0] HALT_MAIN_NOVEC = 11'h009;
   localparam logic [CNT_W-1:0] HALT_MAIN_VEC = 11'h00F;
   localparam logic [CNT_W-1:0] HALT_SUB0_VEC = 11'h00A;
   localparam logic [CNT_W-1:0] HALT_SUB1_VEC = 11'h00B;
   localparam logic [CNT_W-1:0] HALT_SUB0_NOVEC = 11'h004;
   localparam logic [CNT_W-1:0] HALT_SUB1_NOVEC = 11'h005;
   localparam logic [CNT_W-1:0] STOP_HS_VEC = 11'h007;
   localparam logic [CNT_W-1:0] STOP_HS_NOVEC = 11'h001;
   localparam logic [CNT_W-1:0] STOP_X1_VEC = 11'h00A;
   localparam logic [CNT_W-1:0] STOP_X1_NOVEC = 11'h004;

   // clock restart interval after stop
   localparam int CLK_PERIOD_NS = 40;
   localparam int RESTART_MIN_US = 18;
   localparam int RESTART_MAX_US = 65;
   localparam int RESTART_MIN_CYC = (RESTART_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTART_MAX_CYC = (RESTART_MAX_US * 1000) / CLK_PERIOD_NS;
endpackage

// ************************************************************
// wait timer
// ************************************************************
module shsc_wait_timer #(
   parameter int W = 11
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [W-1:0] len,
   output logic done
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;

   // load wins; a load of n gives done in the n-th cycle after it
   always_comb begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = len;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // done on the last counted cycle; must not look at load, as the owner reloads on done
   assign done = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule

/* File: verilog/shsc_standby_ctrl.sv */
// standby controller: halt and stop entry, release by interrupt or reset,
// clock gating, oscillator and peripheral wake controls, axi4-lite registers.
// assumes cpu and interrupt controller run on aclk; inputs need no sync.
//
// Overview of operation
// - hold all state while halted or stopped
// - pending unmasked interrupt skips halt entry
// - unmasked interrupt ends halt, vectored or sequential
// - halt, subclock, low power off, vectored: 10
// - halt, subclock, low power on, vectored: 11
// - halt, main clock, not vectored: 9 clocks
// - halt, subclock, low power off, sequential: 4
// - reset ends standby, restarts from vector
// - stop only from main clock sources
// - pending interrupt at stop: immediate release sequence
// - stop gates cpu clock, stops main oscillators
// - subclocks and port latches kept in stop
// - low-speed oscillator per timer and watchdog bits
// - in stop, clock output runs only on subclock, low power off
// - a/d converter may wake into snooze
// - only csi and uart channels may wake
// - i2c unit wakes on address match
// - stop auto-halts cpu, memories, crc, guards
// - unmasked interrupt ends stop after stabilisation
// - high-speed oscillator restart gates clock 18-65 us
// - then 7 clocks before vectored service
// - then 1 clock before next instruction
`timescale 1ns/100ps
module shsc_standby_ctrl #(
   parameter int RESTART_CYC = shsc_pkg::RESTART_MIN_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic halt_req,
   input wire logic stop_req,
   input wire shsc_pkg::shsc_clk_src_t cpu_clk_src,
   input wire logic int_pending,
   input wire logic int_ack_enable,
   output logic cpu_clk_en,
   output logic cpu_resume,
   output logic resume_vectored,
   output logic state_hold,
   output logic mem_auto_halt,
   output logic hs_internal_osc_clk_en,
   output logic main_crystal_clk_en,
   output logic ext_main_clk_en,
   output logic sub_crystal_clk_en,
   output logic ls_internal_osc_clk_en,
   output logic clkout_en,
   output logic adc_wake_en,
   output logic clocked_serial_chan_wake_en,
   output logic async_serial_chan_wake_en,
   output logic serial_array_other_en,
   output logic i2c_unit_addr_wake_en
);
   import shsc_pkg::*;

   typedef enum logic [2:0] {ST_RUN, ST_HALT, ST_STOP, ST_RESTART, ST_WAIT} shsc_state_t;

   localparam logic [CNT_W-1:0] RESTART_LEN = CNT_W'(RESTART_CYC);

   // ************************************************************
   // wait length selection
   // ************************************************************
   // halt release wait depends on the clock the cpu was on
   function automatic logic [CNT_W-1:0] halt_wait(input shsc_clk_src_t src, input logic lp,
                                                  input logic vec);
      logic [CNT_W-1:0] w;
      w = vec ? HALT_MAIN_VEC : HALT_MAIN_NOVEC;
      if (src == CLK_SUBSYSTEM) begin
         if (vec) begin
            w = lp ? HALT_SUB1_VEC : HALT_SUB0_VEC;
         end else begin
            w = lp ? HALT_SUB1_NOVEC : HALT_SUB0_NOVEC;
         end
      end
      return w;
   endfunction

   // crystal restart adds a longer settle than the internal oscillator
   function automatic logic [CNT_W-1:0] stop_wait(input shsc_clk_src_t src, input logic vec);
      logic [CNT_W-1:0] w;
      w = vec ? STOP_HS_VEC : STOP_HS_NOVEC;
      if (src == CLK_MAIN_CRYSTAL) begin
         w = vec ? STOP_X1_VEC : STOP_X1_NOVEC;
      end
      return w;
   endfunction

   // ************************************************************
   // declarations
   // ************************************************************
   shsc_state_t st_q, st_d;
   shsc_clk_src_t src_q, src_d;
   logic vec_q, vec_d;
   logic resume_q, resume_d;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_len;
   logic tmr_done;
   logic skip_set, refuse_set;
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [OPT_W-1:0] opt_q, opt_d;
   logic skip_q, skip_d, refuse_q, refuse_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [11:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic w_lane0_q, w_lane0_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic do_wr;
   logic lp;
   logic standby, in_stop;
   logic [31:0] stat_word;

   assign lp = ctrl_q[CTRL_LP_BIT];

   // ************************************************************
   // standby state machine
   // ************************************************************
   always_comb begin
      st_d = st_q;
      src_d = src_q;
      vec_d = vec_q;
      resume_d = 1'b0;
      tmr_load = 1'b0;
      tmr_len = '0;
      skip_set = 1'b0;
      refuse_set = 1'b0;
      unique case (st_q)
         ST_RUN: begin
            if (stop_req) begin
               if (cpu_clk_src == CLK_SUBSYSTEM) begin
                  refuse_set = 1'b1;
               end else if (int_pending) begin
                  // pending request: straight into the release sequence
                  src_d = cpu_clk_src;
                  st_d = ST_RESTART;
                  tmr_load = 1'b1;
                  tmr_len = RESTART_LEN;
               end else begin
                  src_d = cpu_clk_src;
                  st_d = ST_STOP;
               end
            end else if (halt_req) begin
               if (int_pending) begin
                  skip_set = 1'b1;
               end else begin
                  src_d = cpu_clk_src;
                  st_d = ST_HALT;
               end
            end
         end
         ST_HALT: begin
            if (int_pending) begin
               // release wait from source, low power bit and acceptance
               vec_d = int_ack_enable;
               st_d = ST_WAIT;
               tmr_load = 1'b1;
               tmr_len = halt_wait(src_q, lp, int_ack_enable);
            end
         end
         ST_STOP: begin
            if (int_pending) begin
               st_d = ST_RESTART;
               tmr_load = 1'b1;
               tmr_len = RESTART_LEN;
            end
         end
         ST_RESTART: begin
            if (tmr_done) begin
               // acceptance sampled once the clock is back
               vec_d = int_ack_enable;
               st_d = ST_WAIT;
               tmr_load = 1'b1;
               tmr_len = stop_wait(src_q, int_ack_enable);
            end
         end
         ST_WAIT: begin
            if (tmr_done) begin
               st_d = ST_RUN;
               resume_d = 1'b1;
            end
         end
      endcase
   end

   // synchronous reset drops any standby state at once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= ST_RUN;
         src_q <= CLK_HS_INTERNAL_OSC;
         vec_q <= 1'b0;
         resume_q <= 1'b0;
      end else begin
         st_q <= st_d;
         src_q <= src_d;
         vec_q <= vec_d;
         resume_q <= resume_d;
      end
   end

   shsc_wait_timer #(
      .W(CNT_W)
   ) u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(tmr_load),
      .len(tmr_len),
      .done(tmr_done)
   );

   // ************************************************************
   // clock and peripheral controls
   // ************************************************************
   // restart counts as standby: clock stays gated until it is stable
   assign standby = (st_q == ST_HALT) || (st_q == ST_STOP) || (st_q == ST_RESTART);
   assign in_stop = (st_q == ST_STOP);
   assign cpu_clk_en = !standby;
   assign state_hold = standby;
   assign mem_auto_halt = standby;
   assign hs_internal_osc_clk_en = !in_stop;
   assign main_crystal_clk_en = !in_stop;
   assign ext_main_clk_en = !in_stop;
   assign sub_crystal_clk_en = ctrl_q[CTRL_SUBXT_BIT];
   assign ls_internal_osc_clk_en = !standby || ctrl_q[CTRL_ITC_BIT] ||
      (opt_q[OPT_WDEN_BIT] && opt_q[OPT_WDSTBY_BIT]);
   assign clkout_en = ctrl_q[CTRL_CO_EN_BIT] &&
      (!in_stop || (ctrl_q[CTRL_CO_SUB_BIT] && !lp));
   assign adc_wake_en = in_stop;
   assign clocked_serial_chan_wake_en = in_stop;
   assign async_serial_chan_wake_en = in_stop;
   assign serial_array_other_en = !in_stop;
   assign i2c_unit_addr_wake_en = in_stop;
   assign cpu_resume = resume_q;
   assign resume_vectored = vec_q;

   // ************************************************************
   // axi4-lite slave
   // ************************************************************
   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign do_wr = aw_have_q && w_have_q && !bvalid_q;

   assign stat_word = {23'h000000, standby, 1'b0, vec_q, refuse_q, skip_q, 1'b0,
                       3'(st_q)};

   // address and data are held separately so either may come first
   always_comb begin
      aw_have_d = aw_have_q;
      aw_addr_d = aw_addr_q;
      w_have_d = w_have_q;
      w_data_d = w_data_q;
      w_lane0_d = w_lane0_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      ctrl_d = ctrl_q;
      opt_d = opt_q;
      skip_d = skip_q | skip_set;
      refuse_d = refuse_q | refuse_set;
      if (s_axi_awvalid && !aw_have_q) begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q) begin
         w_have_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_lane0_d = s_axi_wstrb[0];
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (do_wr) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = 2'h0;
         // all writable fields live in byte lane 0
         if (aw_addr_q[11:2] == CTRL_OFS[11:2]) begin
            if (w_lane0_q) ctrl_d = w_data_q[CTRL_W-1:0];
         end else if (aw_addr_q[11:2] == OPT_OFS[11:2]) begin
            if (w_lane0_q) opt_d = w_data_q[OPT_W-1:0];
         end else if (aw_addr_q[11:2] == STAT_OFS[11:2]) begin
            // write one to clear; a same-cycle event keeps its flag
            if (w_lane0_q) begin
               skip_d = (skip_q & ~w_data_q[STAT_SKIP_BIT]) | skip_set;
               refuse_d = (refuse_q & ~w_data_q[STAT_REFUSE_BIT]) | refuse_set;
            end
         end else begin
            bresp_d = 2'h2;
         end
      end
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d = 2'h0;
         rdata_d = 32'h00000000;
         if (s_axi_araddr[11:2] == CTRL_OFS[11:2]) begin
            rdata_d = {27'h0000000, ctrl_q};
         end else if (s_axi_araddr[11:2] == OPT_OFS[11:2]) begin
            rdata_d = {27'h0000000, opt_q};
         end else if (s_axi_araddr[11:2] == STAT_OFS[11:2]) begin
            rdata_d = stat_word;
         end else begin
            rresp_d = 2'h2;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 12'h000;
         w_have_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_lane0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         rvalid_q <= 1'b0;
         rresp_q <= 2'h0;
         rdata_q <= 32'h00000000;
         ctrl_q <= CTRL_RST;
         opt_q <= OPT_RST;
         skip_q <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         aw_have_q <= aw_have_d;
         aw_addr_q <= aw_addr_d;
         w_have_q <= w_have_d;
         w_data_q <= w_data_d;
         w_lane0_q <= w_lane0_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         opt_q <= opt_d;
         skip_q <= skip_d;
         refuse_q <= refuse_d;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   // restart length counter, read only by the checks below
   logic [CNT_W-1:0] rs_cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || st_q != ST_RESTART) begin
         rs_cnt_q <= '0;
      end else begin
         rs_cnt_q <= rs_cnt_q + 1'b1;
      end
   end
   // running clocks spent in the release wait, read only by the checks below
   logic [CNT_W-1:0] wt_cnt_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || st_q != ST_WAIT || !cpu_clk_en) begin
         wt_cnt_q <= '0;
      end else begin
         wt_cnt_q <= wt_cnt_q + 1'b1;
      end
   end

   a_halt_skip: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_RUN && halt_req && !stop_req && int_pending |=> st_q == ST_RUN && skip_q)
      else $error("halt entered with a pending interrupt");
   a_halt_sub0_vec: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_HALT && int_pending && src_q == CLK_SUBSYSTEM && !lp && int_ack_enable
      |-> ##11 (cpu_resume && resume_vectored && wt_cnt_q == 11'h00A))
      else $error("halt release wait not 10");
   a_halt_sub1_vec: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_HALT && int_pending && src_q == CLK_SUBSYSTEM && lp && int_ack_enable
      |-> ##12 (cpu_resume && wt_cnt_q == 11'h00B))
      else $error("halt release wait not 11");
   a_halt_main_seq: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_HALT && int_pending && src_q != CLK_SUBSYSTEM && !int_ack_enable
      |-> ##10 (cpu_resume && !resume_vectored && wt_cnt_q == 11'h009))
      else $error("halt release wait not 9");
   a_halt_sub0_seq: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_HALT && int_pending && src_q == CLK_SUBSYSTEM && !lp && !int_ack_enable
      |=> (st_q == ST_WAIT)[*4] ##1 cpu_resume)
      else $error("halt release wait not 4");
   a_reset_run: assert property (@(posedge aclk)
      !aresetn |=> st_q == ST_RUN && cpu_clk_en && !cpu_resume)
      else $error("reset did not leave standby");
   a_stop_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_RUN && stop_req && cpu_clk_src == CLK_SUBSYSTEM |=> st_q == ST_RUN && refuse_q)
      else $error("stop entered from subsystem clock");
   a_stop_pending: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_RUN && stop_req && cpu_clk_src != CLK_SUBSYSTEM && int_pending
      |=> st_q == ST_RESTART && hs_internal_osc_clk_en)
      else $error("pending stop not released at once");
   a_stop_gating: assert property (@(posedge aclk) disable iff (!aresetn)
      in_stop |-> !cpu_clk_en && !hs_internal_osc_clk_en && !main_crystal_clk_en &&
      !ext_main_clk_en && !serial_array_other_en && adc_wake_en && i2c_unit_addr_wake_en)
      else $error("stop gating wrong");
   a_ls_osc: assert property (@(posedge aclk) disable iff (!aresetn)
      standby |-> ls_internal_osc_clk_en == (ctrl_q[CTRL_ITC_BIT] ||
      (opt_q[OPT_WDEN_BIT] && opt_q[OPT_WDSTBY_BIT])))
      else $error("low-speed oscillator control wrong");
   a_clkout_stop: assert property (@(posedge aclk) disable iff (!aresetn)
      in_stop && (lp || !ctrl_q[CTRL_CO_SUB_BIT]) |-> !clkout_en)
      else $error("clock output running in stop");
   a_restart_len: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_RESTART && st_d != ST_RESTART |-> rs_cnt_q == CNT_W'(RESTART_CYC - 1) &&
      RESTART_CYC >= RESTART_MIN_CYC && RESTART_CYC <= RESTART_MAX_CYC && !cpu_clk_en)
      else $error("clock restart interval wrong");
   a_stop_hs_vec: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_RESTART && tmr_done && src_q == CLK_HS_INTERNAL_OSC && int_ack_enable
      |=> (st_q == ST_WAIT)[*7] ##1 (cpu_resume && resume_vectored))
      else $error("stop vectored wait not 7");
   a_stop_hs_seq: assert property (@(posedge aclk) disable iff (!aresetn)
      st_q == ST_RESTART && tmr_done && src_q == CLK_HS_INTERNAL_OSC && !int_ack_enable
      |=> st_q == ST_WAIT ##1 (cpu_resume && st_q == ST_RUN))
      else $error("stop sequential wait not 1");
endmodule

/* File: verification/shsc_cpu_model.sv */
// stand-in for the cpu core and interrupt controller: halt and stop
// instruction pulses and the unmasked-interrupt level.
// assumes the bench commands it just after aclk edges.
`timescale 1ns/100ps
// ************************************************************
// cpu and interrupt controller model
// ************************************************************
module shsc_cpu_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] cmd,
   input wire logic wake,
   output logic halt_req,
   output logic stop_req,
   output logic int_pending
);
   // one-cycle instruction pulses; the bench only asks for stop with peripherals idle
   always_ff @(posedge aclk) begin
      halt_req <= aresetn && cmd == 2'h1;
      stop_req <= aresetn && cmd == 2'h2;
      int_pending <= aresetn && wake; // level held until the bench sees the resume
   end
endmodule

/* File: verification/tb.sv */
// standby controller bench: axi4-lite register tasks and standby scenarios.
// assumes the design package and the cpu model are compiled first.
`timescale 1ns/100ps
// ************************************************************
// bench top
// ************************************************************
module tb;
   import shsc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, wake = 1'b0, int_ack_enable = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [1:0] cmd = 2'h0, s_axi_bresp, s_axi_rresp, r;
   logic [2:0] hs;
   logic [4:0] ctrl_v = 5'h00, opt_v = 5'h00;
   shsc_clk_src_t cpu_clk_src = CLK_HS_INTERNAL_OSC;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic halt_req, stop_req, int_pending, cpu_clk_en, cpu_resume, resume_vectored;
   logic state_hold, mem_auto_halt, hs_internal_osc_clk_en, main_crystal_clk_en;
   logic ext_main_clk_en, sub_crystal_clk_en, ls_internal_osc_clk_en, clkout_en;
   logic adc_wake_en, clocked_serial_chan_wake_en, async_serial_chan_wake_en;
   logic serial_array_other_en, i2c_unit_addr_wake_en;
   int err_count = 0, tests_run = 0;
   // 25 MHz
   always #20 aclk = ~aclk;
   shsc_cpu_model u_shsc_cpu_model (.aclk, .aresetn, .cmd, .wake, .halt_req, .stop_req,
      .int_pending);
   // protection bits are ignored by the slave, so they stay tied
   shsc_standby_ctrl u_shsc_standby_ctrl (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halt_req, .stop_req, .cpu_clk_src,
      .int_pending, .int_ack_enable, .cpu_clk_en, .cpu_resume, .resume_vectored, .state_hold,
      .mem_auto_halt, .hs_internal_osc_clk_en, .main_crystal_clk_en, .ext_main_clk_en,
      .sub_crystal_clk_en, .ls_internal_osc_clk_en, .clkout_en, .adc_wake_en,
      .clocked_serial_chan_wake_en, .async_serial_chan_wake_en, .serial_array_other_en,
      .i2c_unit_addr_wake_en);
   task automatic tally_and_finish;
      if (err_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tmo;
      err_count++;
      tally_and_finish();
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // one axi4-lite transfer; handshakes judged at the negedge before the taking edge
   task automatic ax(input logic we, input logic [11:0] a, input logic [31:0] d);
      logic done;
      int i;
      done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= we;
      s_axi_wvalid <= we;
      s_axi_bready <= we;
      s_axi_arvalid <= !we;
      s_axi_rready <= !we;
      for (i = 0; i < 50 && !done; i++) begin
         @(negedge aclk);
         hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
            s_axi_arvalid & s_axi_arready};
         done = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
         r = we ? s_axi_bresp : s_axi_rresp;
         q = s_axi_rdata;
         @(posedge aclk);
         if (hs[2]) s_axi_awvalid <= 1'b0;
         if (hs[1]) s_axi_wvalid <= 1'b0;
         if (hs[0]) s_axi_arvalid <= 1'b0;
         if (done) s_axi_bready <= 1'b0;
         if (done) s_axi_rready <= 1'b0;
      end
      if (!done) tmo();
   endtask
   // halt or stop instruction, optionally with the interrupt already pending
   task automatic req(input logic stp, input shsc_clk_src_t src, input logic vec, input logic pre);
      @(posedge aclk);
      cpu_clk_src <= src;
      int_ack_enable <= vec;
      wake <= pre;
      cmd <= stp ? 2'h2 : 2'h1;
      @(posedge aclk);
      cmd <= 2'h0;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
   endtask
   // standby round trip; n is the count of running clocks before the resume pulse
   task automatic sb(input logic stp, input shsc_clk_src_t src, input logic vec, input logic pre,
      input int n);
      int c;
      int i;
      req(stp, src, vec, pre);
      if (!pre) begin
         chk("hold", {state_hold, mem_auto_halt, cpu_clk_en}, 3'b110);
         chk("osc", {hs_internal_osc_clk_en, main_crystal_clk_en, ext_main_clk_en}, {3{!stp}});
         chk("subxt", sub_crystal_clk_en, ctrl_v[4]);
         chk("ls", ls_internal_osc_clk_en, ctrl_v[1] | (opt_v[4] & opt_v[0]));
         chk("clkout", clkout_en, ctrl_v[3] & (!stp | (ctrl_v[2] & !ctrl_v[0])));
         chk("wake", {adc_wake_en, i2c_unit_addr_wake_en}, {2{stp}});
         chk("sau", {clocked_serial_chan_wake_en, async_serial_chan_wake_en,
            serial_array_other_en}, {stp, stp, !stp});
         @(posedge aclk);
         wake <= 1'b1;
      end
      c = 0;
      for (i = 0; i < 1000 && cpu_resume !== 1'b1; i++) begin
         @(negedge aclk);
         if (cpu_resume !== 1'b1) c = (cpu_clk_en === 1'b1) ? c + 1 : 0;
      end
      if (cpu_resume !== 1'b1) tmo();
      chk("wait", c, n);
      chk("vec", resume_vectored, vec);
      @(posedge aclk);
      wake <= 1'b0;
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      ax(0, CTRL_OFS, 0);
      chk("ctrl_rst", q, CTRL_RST);
      ax(0, OPT_OFS, 0);
      chk("opt_rst", q, OPT_RST);
      ax(0, 12'h00C, 0);
      chk("rresp", r, 2'h2);
      ax(1, 12'h00C, 32'hFFFF_FFFF);
      chk("bresp", r, 2'h2);
      ax(1, CTRL_OFS, 32'hFFFF_FFEE);
      ctrl_v = 5'h0E;
      ax(0, CTRL_OFS, 0);
      chk("ctrl", q, 32'h0000_000E);
      sb(1, CLK_HS_INTERNAL_OSC, 1, 0, 7);
      ax(1, CTRL_OFS, 32'h0000_0019);
      ctrl_v = 5'h19;
      sb(1, CLK_EXT_MAIN, 0, 0, 1);
      ax(1, OPT_OFS, 32'h0000_0011);
      opt_v = 5'h11;
      sb(0, CLK_SUBSYSTEM, 1, 0, 11);
      ax(1, CTRL_OFS, 0);
      ctrl_v = 5'h00;
      sb(0, CLK_SUBSYSTEM, 1, 0, 10);
      sb(0, CLK_SUBSYSTEM, 0, 0, 4);
      sb(0, CLK_MAIN_CRYSTAL, 0, 0, 9);
      sb(1, CLK_HS_INTERNAL_OSC, 1, 1, 7);
      req(0, CLK_HS_INTERNAL_OSC, 0, 1);
      chk("skip", {cpu_clk_en, state_hold}, 2'b10);
      req(1, CLK_SUBSYSTEM, 0, 0);
      chk("refuse", {cpu_clk_en, state_hold}, 2'b10);
      ax(0, STAT_OFS, 0);
      chk("status", {q[5:4], q[2:0]}, 5'b11000);
      req(0, CLK_HS_INTERNAL_OSC, 0, 0);
      chk("halted", state_hold, 1'b1);
      @(posedge aclk);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk("reset", {cpu_clk_en, state_hold, cpu_resume}, 3'b100);
      tally_and_finish();
   end
endmodule
